// ### rtl/receiver_lock_manager.sv
// Behaviour
// - Valid needs lock and idle manager
// - Activity low means signal present
// - Fine lock within 4000 ppm tolerance
// - Async eye recentering request
// - Async coefficient recalibration request
// - Eye done after recentering, or at once in no-cal
// - Coefficient done after recalibration, or at once in no-cal and fixed eq
// - No-cal: static, reference tracking only
// - First lock plus on demand calibration
// - On demand: calibrate only on request
// - Calibrating high from full request to completion
// - Fixed eq: DC offset, register coefficients
// - Fixed equalizer never runs equalizer autocal
// - Calibration request acts on rising edge
// - Loss of signal honoured only before tracking
module receiver_lock_manager (
  input  wire logic                 mclk,
  input  wire logic                 rst,
  input  wire rlm_pkg::rlm_bus_req_t busReq,
  output logic [rlm_pkg::DATA_W-1:0] busRdata,
  output logic                      irq,
  input  wire rlm_pkg::rlm_pma_stat_t pmaStat,
  output rlm_pkg::rlm_cal_cmd_t     calCmd,
  output logic                      dataTrackingMode,
  input  wire logic                 calRequest,
  input  wire logic                 eyeRecalRequest,
  input  wire logic                 equalizerCoeffRecalRequest,
  input  wire logic                 lossOfSignalIn,
  output logic                      rxDataValidFlag,
  output logic                      rxReadyFlag,
  output logic                      rxActiveN,
  output logic                      calibrating,
  output logic                      eyeRecalDone,
  output logic                      equalizerCoeffRecalDone
);

  logic [rlm_pkg::SYN_W-1:0]   syncReq;
  logic [rlm_pkg::SYN_W-1:0]   syncPrev_reg;
  logic [rlm_pkg::SYN_W-1:0]   syncRise;
  logic [rlm_pkg::CTRL_W-1:0]  ctrl_reg;
  logic [rlm_pkg::EV_W-1:0]    status_reg;
  logic [rlm_pkg::EV_W-1:0]    status_next;
  logic [rlm_pkg::EV_W-1:0]    mask_reg;
  logic [rlm_pkg::COEF_W-1:0]  coef_reg;
  logic [rlm_pkg::CNT_W-1:0]   calCount_reg;
  logic [rlm_pkg::TMO_W-1:0]   tmo_reg;
  logic [rlm_pkg::EV_W-1:0]    events;
  rlm_pkg::rlm_state_t         state_reg;
  rlm_pkg::rlm_state_t         state_next;
  rlm_pkg::rlm_option_t        option;
  rlm_pkg::rlm_cal_kind_t      kind_reg;
  rlm_pkg::rlm_cal_kind_t      kindPick;
  logic                        firstPend_reg;
  logic                        pendFull_reg;
  logic                        pendEye_reg;
  logic                        pendCoeff_reg;
  logic                        busy_reg;
  logic                        lockNow;
  logic                        opsDone;
  logic                        fullWanted;
  logic                        anyPend;
  logic                        calFinish;
  logic                        calTimeout;
  logic                        calEnd;
  logic                        swReq;
  logic                        fullReq;
  logic                        eyeReq;
  logic                        coeffReq;
  logic                        eyeBypass;
  logic                        coeffBypass;
  logic                        eyeFinish;
  logic                        coeffFinish;
  logic                        fullFinish;
  logic                        valid_next;
  logic                        enterCal;

  // Requests cross clock domains before edge detection
  rlm_sync_bits #(
    .W (rlm_pkg::SYN_W)
  ) u_sync (
    .mclk    (mclk),
    .rst     (rst),
    .asyncIn ({lossOfSignalIn, equalizerCoeffRecalRequest, eyeRecalRequest, calRequest}),
    .syncOut (syncReq)
  );

  // Reset high like the synchroniser, so no false edge follows reset
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      syncPrev_reg <= '1;
    end else begin
      syncPrev_reg <= syncReq;
    end
  end

  assign syncRise = syncReq & ~syncPrev_reg;

  // Decoded qualifiers
  assign option   = rlm_pkg::rlm_option_t'(ctrl_reg[rlm_pkg::CTRL_OPT_LSB +: rlm_pkg::CTRL_OPT_W]);
  assign swReq    = busReq.wr && (busReq.addr == rlm_pkg::OFS_CTRL)
                    && busReq.wdata[rlm_pkg::CTRL_SWREQ_BIT];
  // No-cal option drops full calibration requests; eye and coefficient requests are answered at once
  assign fullReq  = (syncRise[rlm_pkg::SYN_CAL] || swReq)
                    && (option != rlm_pkg::OPT_NO_CAL_RECOVERY);
  assign eyeReq   = syncRise[rlm_pkg::SYN_EYE];
  assign coeffReq = syncRise[rlm_pkg::SYN_COEFF];
  // Nothing to recalibrate: answer at once
  assign eyeBypass   = eyeReq && (option == rlm_pkg::OPT_NO_CAL_RECOVERY);
  assign coeffBypass = coeffReq && ((option == rlm_pkg::OPT_NO_CAL_RECOVERY)
                       || (option == rlm_pkg::OPT_FIXED_EQUALIZER));

  // Fine lock: PLL locked, error in tolerance
  assign lockNow = pmaStat.pllLock && (pmaStat.freqErrPpm <= rlm_pkg::LOCK_TOL_PPM);

  // First-lock calibration for options 1 and 3
  assign fullWanted = pendFull_reg || (firstPend_reg
                      && ((option == rlm_pkg::OPT_FIRST_AND_DEMAND)
                      || (option == rlm_pkg::OPT_FIXED_EQUALIZER)));
  assign anyPend    = fullWanted || pendEye_reg || pendCoeff_reg;

  // Full beats incremental
  always_comb begin
    kindPick = rlm_pkg::CAL_COEFF;
    if (fullWanted) begin
      if (option == rlm_pkg::OPT_FIXED_EQUALIZER) begin
        kindPick = rlm_pkg::CAL_DC_OFFSET;
      end else begin
        kindPick = rlm_pkg::CAL_FULL;
      end
    end else if (pendEye_reg) begin
      kindPick = rlm_pkg::CAL_EYE;
    end
  end

  // Calibration end or timeout
  assign calFinish   = (state_reg == rlm_pkg::ST_CALIBRATE) && pmaStat.calDone;
  assign calTimeout  = (state_reg == rlm_pkg::ST_CALIBRATE) && !pmaStat.calDone
                       && (tmo_reg == rlm_pkg::CAL_TIMEOUT_CYC);
  assign calEnd      = calFinish || calTimeout;
  assign fullFinish  = calEnd && ((kind_reg == rlm_pkg::CAL_FULL)
                       || (kind_reg == rlm_pkg::CAL_DC_OFFSET));
  assign eyeFinish   = (calEnd && (kind_reg == rlm_pkg::CAL_EYE)) || eyeBypass;
  assign coeffFinish = (calEnd && (kind_reg == rlm_pkg::CAL_COEFF)) || coeffBypass;
  assign enterCal    = (state_reg == rlm_pkg::ST_DATA_TRACK) && lockNow && anyPend;

  // Lane state machine
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      rlm_pkg::ST_REF_TRACK: begin
        // LOS only matters before data tracking
        if ((option != rlm_pkg::OPT_NO_CAL_RECOVERY) && pmaStat.sigDetect
            && !syncReq[rlm_pkg::SYN_LOS]) begin
          state_next = rlm_pkg::ST_ACQUIRE;
        end
      end
      rlm_pkg::ST_ACQUIRE: begin
        if (option == rlm_pkg::OPT_NO_CAL_RECOVERY) begin
          state_next = rlm_pkg::ST_REF_TRACK;
        end else if (lockNow) begin
          state_next = rlm_pkg::ST_DATA_TRACK;
        end
      end
      rlm_pkg::ST_CALIBRATE: begin
        if (calEnd) begin
          state_next = rlm_pkg::ST_DATA_TRACK;
        end
      end
      rlm_pkg::ST_DATA_TRACK: begin
        if (option == rlm_pkg::OPT_NO_CAL_RECOVERY) begin
          state_next = rlm_pkg::ST_REF_TRACK;
        end else if (!lockNow) begin
          state_next = rlm_pkg::ST_ACQUIRE;
        end else if (anyPend) begin
          state_next = rlm_pkg::ST_CALIBRATE;
        end
      end
      default: begin
        state_next = rlm_pkg::ST_REF_TRACK;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_reg <= rlm_pkg::ST_REF_TRACK;
    end else begin
      state_reg <= state_next;
    end
  end

  // Kind latched on entry
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      kind_reg <= rlm_pkg::CAL_FULL;
    end else if (enterCal) begin
      kind_reg <= kindPick;
    end
  end

  // Timeout guards against a silent engine
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tmo_reg <= '0;
    end else if (state_reg != rlm_pkg::ST_CALIBRATE) begin
      tmo_reg <= '0;
    end else if (tmo_reg != rlm_pkg::CAL_TIMEOUT_CYC) begin
      tmo_reg <= tmo_reg + 12'h001;
    end
  end

  // First-lock flag: armed by reset
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      firstPend_reg <= 1'b1;
    end else if (fullFinish || (option == rlm_pkg::OPT_ON_DEMAND)
                 || (option == rlm_pkg::OPT_NO_CAL_RECOVERY)) begin
      firstPend_reg <= 1'b0;
    end
  end

  // Pending requests; a new one beats a clear
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pendFull_reg  <= 1'b0;
      pendEye_reg   <= 1'b0;
      pendCoeff_reg <= 1'b0;
    end else begin
      if (fullReq) begin
        pendFull_reg <= 1'b1;
      end else if (enterCal && ((kindPick == rlm_pkg::CAL_FULL)
                   || (kindPick == rlm_pkg::CAL_DC_OFFSET))) begin
        pendFull_reg <= 1'b0;
      end
      if (eyeReq && !eyeBypass) begin
        pendEye_reg <= 1'b1;
      end else if (enterCal && (kindPick == rlm_pkg::CAL_EYE)) begin
        pendEye_reg <= 1'b0;
      end
      if (coeffReq && !coeffBypass) begin
        pendCoeff_reg <= 1'b1;
      end else if (enterCal && (kindPick == rlm_pkg::CAL_COEFF)) begin
        pendCoeff_reg <= 1'b0;
      end
    end
  end

  // Busy from full request to completion
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      busy_reg <= 1'b0;
    end else if (fullReq || (enterCal && fullWanted)) begin
      busy_reg <= 1'b1;
    end else if (fullFinish && !pendFull_reg) begin
      busy_reg <= 1'b0;
    end
  end

  assign calibrating = busy_reg;

  // Done stays high until the request drops
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      eyeRecalDone            <= 1'b0;
      equalizerCoeffRecalDone <= 1'b0;
    end else begin
      if (eyeFinish) begin
        eyeRecalDone <= 1'b1;
      end else if (!syncReq[rlm_pkg::SYN_EYE]) begin
        eyeRecalDone <= 1'b0;
      end
      if (coeffFinish) begin
        equalizerCoeffRecalDone <= 1'b1;
      end else if (!syncReq[rlm_pkg::SYN_COEFF]) begin
        equalizerCoeffRecalDone <= 1'b0;
      end
    end
  end

  // Valid once locked and idle
  assign opsDone    = ((state_reg == rlm_pkg::ST_DATA_TRACK) && !anyPend && !busy_reg)
                      || ((option == rlm_pkg::OPT_NO_CAL_RECOVERY) && !busy_reg);
  assign valid_next = lockNow && opsDone;

  // Registered lane status
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rxDataValidFlag  <= 1'b0;
      rxReadyFlag      <= 1'b0;
      rxActiveN        <= 1'b1;
      dataTrackingMode <= 1'b0;
    end else begin
      rxDataValidFlag  <= valid_next;
      rxReadyFlag      <= lockNow;
      rxActiveN        <= !pmaStat.sigDetect;
      dataTrackingMode <= (state_next != rlm_pkg::ST_REF_TRACK);
    end
  end

  // Calibration engine command
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      calCmd <= '0;
    end else begin
      calCmd.start    <= enterCal;
      calCmd.kind     <= enterCal ? kindPick : calCmd.kind;
      calCmd.eqAutoEn <= (option == rlm_pkg::OPT_FIRST_AND_DEMAND)
                         || (option == rlm_pkg::OPT_ON_DEMAND);
      calCmd.eqCoef   <= coef_reg;
    end
  end

  // Control, mask and coefficient registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_reg <= rlm_pkg::CTRL_RST;
      mask_reg <= rlm_pkg::MASK_RST;
      coef_reg <= rlm_pkg::COEF_RST;
    end else if (busReq.wr) begin
      if (busReq.addr == rlm_pkg::OFS_CTRL) begin
        ctrl_reg <= busReq.wdata[rlm_pkg::CTRL_W-1:0];
      end
      if (busReq.addr == rlm_pkg::OFS_MASK) begin
        mask_reg <= busReq.wdata[rlm_pkg::EV_W-1:0];
      end
      if (busReq.addr == rlm_pkg::OFS_COEF) begin
        coef_reg <= busReq.wdata[rlm_pkg::COEF_W-1:0];
      end
    end
  end

  // Completed calibrations, wraps
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      calCount_reg <= '0;
    end else if (calFinish) begin
      calCount_reg <= calCount_reg + 16'h0001;
    end
  end

  // Sticky events; set beats clear
  always_comb begin
    events = '0;
    events[rlm_pkg::EV_CAL_DONE]   = fullFinish;
    events[rlm_pkg::EV_EYE_DONE]   = eyeFinish;
    events[rlm_pkg::EV_COEFF_DONE] = coeffFinish;
    events[rlm_pkg::EV_LOCK_LOST]  = rxReadyFlag && !lockNow;
    events[rlm_pkg::EV_TIMEOUT]    = calTimeout;
    status_next = status_reg;
    if (busReq.wr && (busReq.addr == rlm_pkg::OFS_STATUS)) begin
      status_next = status_reg & ~busReq.wdata[rlm_pkg::EV_W-1:0];
    end
    status_next = status_next | events;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      status_reg <= '0;
      irq        <= 1'b0;
    end else begin
      status_reg <= status_next;
      irq        <= |(status_next & mask_reg);
    end
  end

  // Read data for one cycle after the strobe
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      busRdata <= '0;
    end else begin
      busRdata <= '0;
      if (busReq.rd) begin
        case (busReq.addr)
          rlm_pkg::OFS_CTRL: begin
            busRdata[rlm_pkg::CTRL_W-1:0] <= ctrl_reg;
          end
          rlm_pkg::OFS_STATUS: begin
            busRdata[rlm_pkg::EV_W-1:0] <= status_reg;
          end
          rlm_pkg::OFS_MASK: begin
            busRdata[rlm_pkg::EV_W-1:0] <= mask_reg;
          end
          rlm_pkg::OFS_STATE: begin
            busRdata[rlm_pkg::STA_STATE_LSB +: 2] <= state_reg;
            busRdata[rlm_pkg::STA_BUSY_BIT]       <= busy_reg;
            busRdata[rlm_pkg::STA_VALID_BIT]      <= rxDataValidFlag;
            busRdata[rlm_pkg::STA_READY_BIT]      <= rxReadyFlag;
            busRdata[rlm_pkg::STA_TRACK_BIT]      <= dataTrackingMode;
            busRdata[rlm_pkg::STA_FIRST_BIT]      <= firstPend_reg;
          end
          rlm_pkg::OFS_COEF: begin
            busRdata[rlm_pkg::COEF_W-1:0] <= coef_reg;
          end
          rlm_pkg::OFS_COUNT: begin
            busRdata[rlm_pkg::CNT_W-1:0] <= calCount_reg;
          end
          default: begin
            busRdata <= '0;
          end
        endcase
      end
    end
  end

endmodule

// ### pkg/rlm_pkg.sv
package rlm_pkg;

  // Register bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_MASK   = 8'h08;
  localparam logic [7:0] OFS_STATE  = 8'h0C;
  localparam logic [7:0] OFS_COEF   = 8'h10;
  localparam logic [7:0] OFS_COUNT  = 8'h14;

  // Control register fields
  localparam int CTRL_OPT_LSB    = 0;
  localparam int CTRL_OPT_W      = 2;
  localparam int CTRL_HIRATE_BIT = 2;
  localparam int CTRL_SWREQ_BIT  = 3;
  localparam int CTRL_W          = 3;
  localparam logic [2:0] CTRL_RST = 3'h1;

  // Status, mask and interrupt bit positions
  localparam int EV_CAL_DONE   = 0;
  localparam int EV_EYE_DONE   = 1;
  localparam int EV_COEFF_DONE = 2;
  localparam int EV_LOCK_LOST  = 3;
  localparam int EV_TIMEOUT    = 4;
  localparam int EV_W          = 5;
  localparam logic [4:0] MASK_RST = 5'h00;

  // State register fields
  localparam int STA_STATE_LSB = 0;
  localparam int STA_BUSY_BIT  = 2;
  localparam int STA_VALID_BIT = 3;
  localparam int STA_READY_BIT = 4;
  localparam int STA_TRACK_BIT = 5;
  localparam int STA_FIRST_BIT = 6;

  // Static equalizer coefficients
  localparam int COEF_W = 16;
  localparam logic [15:0] COEF_RST = 16'h0000;

  // Calibration counter
  localparam int CNT_W = 16;

  // Fine lock tolerance
  localparam int PPM_W = 13;
  localparam logic [12:0] LOCK_TOL_PPM = 13'd4000;

  // Timing
  localparam int CLK_MHZ        = 20;
  localparam int CAL_TIMEOUT_US = 100;
  localparam int TMO_W          = 12;
  localparam logic [11:0] CAL_TIMEOUT_CYC = 12'(CAL_TIMEOUT_US * CLK_MHZ);

  // Synchronised request bit positions
  localparam int SYN_CAL   = 0;
  localparam int SYN_EYE   = 1;
  localparam int SYN_COEFF = 2;
  localparam int SYN_LOS   = 3;
  localparam int SYN_W     = 4;

  typedef enum logic [1:0] {
    OPT_NO_CAL_RECOVERY,
    OPT_FIRST_AND_DEMAND,
    OPT_ON_DEMAND,
    OPT_FIXED_EQUALIZER
  } rlm_option_t;

  typedef enum logic [1:0] {
    CAL_FULL,
    CAL_EYE,
    CAL_COEFF,
    CAL_DC_OFFSET
  } rlm_cal_kind_t;

  typedef enum logic [1:0] {
    ST_REF_TRACK,
    ST_ACQUIRE,
    ST_CALIBRATE,
    ST_DATA_TRACK
  } rlm_state_t;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } rlm_bus_req_t;

  typedef struct packed {
    logic             sigDetect;
    logic             pllLock;
    logic [PPM_W-1:0] freqErrPpm;
    logic             calDone;
  } rlm_pma_stat_t;

  typedef struct packed {
    logic              start;
    rlm_cal_kind_t     kind;
    logic              eqAutoEn;
    logic [COEF_W-1:0] eqCoef;
  } rlm_cal_cmd_t;

endpackage

// ### rtl/rlm_sync_bits.sv
module rlm_sync_bits #(
  parameter int W = 4
) (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);

  logic [W-1:0] stage1Reg;
  logic [W-1:0] stage2Reg;

  // Resets high so loss of signal reads as present until sampled
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        stage1Reg[i] <= 1'b1;
        stage2Reg[i] <= 1'b1;
      end else begin
        stage1Reg[i] <= asyncIn[i];
        stage2Reg[i] <= stage1Reg[i];
      end
    end
  end

  assign syncOut = stage2Reg;

endmodule

// ### sim/rlm_pma_model.sv
module rlm_pma_model (
  input  wire logic                     mclk,
  input  wire logic                     rst,
  input  wire rlm_pkg::rlm_cal_cmd_t    calCmd,
  input  wire logic                     sigIn,
  input  wire logic                     lockIn,
  input  wire logic [rlm_pkg::PPM_W-1:0] ppmIn,
  input  wire logic                     slowIn,
  output rlm_pkg::rlm_pma_stat_t        pmaStat,
  output logic [7:0]                    starts,
  output rlm_pkg::rlm_cal_kind_t        lastKind
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0] runCnt;
  logic       doneReg;
  // One run at a time
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      runCnt   <= 6'h00;
      doneReg  <= 1'b0;
      starts   <= 8'h00;
      lastKind <= rlm_pkg::CAL_FULL;
    end else begin
      doneReg <= (runCnt == 6'h01);
      if (calCmd.start) begin
        runCnt   <= slowIn ? 6'h28 : 6'h04;
        starts   <= starts + 8'h01;
        lastKind <= calCmd.kind;
      end else if (runCnt != 6'h00) begin
        runCnt <= runCnt - 6'h01;
      end
    end
  end
  // One-cycle done pulse the manager must catch
  assign pmaStat = '{sigDetect: sigIn, pllLock: lockIn, freqErrPpm: ppmIn, calDone: doneReg};
endmodule

// ### sim/rlm_properties.sv
module rlm_properties (
  input wire logic                       mclk,
  input wire logic                       rst,
  input wire rlm_pkg::rlm_bus_req_t      busReq,
  input wire logic [rlm_pkg::DATA_W-1:0] busRdata,
  input wire logic                       irq,
  input wire rlm_pkg::rlm_pma_stat_t     pmaStat,
  input wire rlm_pkg::rlm_cal_cmd_t      calCmd,
  input wire logic                       dataTrackingMode,
  input wire logic                       calRequest,
  input wire logic                       eyeRecalRequest,
  input wire logic                       equalizerCoeffRecalRequest,
  input wire logic                       lossOfSignalIn,
  input wire logic                       rxDataValidFlag,
  input wire logic                       rxReadyFlag,
  input wire logic                       rxActiveN,
  input wire logic                       calibrating,
  input wire logic                       eyeRecalDone,
  input wire logic                       equalizerCoeffRecalDone
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] optReg;
  logic       fineLock;
  // Option shadow; not visible at the ports
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      optReg <= rlm_pkg::CTRL_RST[1:0];
    end else if (busReq.wr && busReq.addr == rlm_pkg::OFS_CTRL) begin
      optReg <= busReq.wdata[1:0];
    end
  end
  assign fineLock = pmaStat.pllLock && (pmaStat.freqErrPpm <= rlm_pkg::LOCK_TOL_PPM);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // Option settled for registered outputs
  sequence s_opt_none;
    (optReg == 2'h0) [*4];
  endsequence
  sequence s_opt_fixed;
    (optReg == 2'h3) [*4];
  endsequence
  chk_valid_needs_lock: assert property ($past(!fineLock) |-> !rxDataValidFlag)
    else $error("valid without lock");
  chk_activity_low: assert property (!$past(rst) |-> rxActiveN == !$past(pmaStat.sigDetect))
    else $error("activity polarity");
  chk_ready_ppm: assert property (!$past(rst) |-> rxReadyFlag == $past(fineLock))
    else $error("ready off tolerance");
  chk_full_busy: assert property (calCmd.start && calCmd.kind == rlm_pkg::CAL_FULL |-> calibrating)
    else $error("full cal not busy");
  chk_nocal_ref: assert property (s_opt_none |-> !dataTrackingMode && !calCmd.start)
    else $error("no-cal left ref track");
  chk_fixed_noauto: assert property (s_opt_fixed ##0 calCmd.start |->
    calCmd.kind != rlm_pkg::CAL_FULL && calCmd.kind != rlm_pkg::CAL_COEFF && !calCmd.eqAutoEn)
    else $error("fixed option ran eq cal");
  chk_eye_handshake: assert property ($rose(eyeRecalDone) |-> $past(eyeRecalRequest, 3))
    else $error("eye done unrequested");
  chk_coeff_handshake: assert property ($rose(equalizerCoeffRecalDone) |->
    $past(equalizerCoeffRecalRequest, 3))
    else $error("coeff done unrequested");
  chk_coeff_release: assert property (!equalizerCoeffRecalRequest [*5] |-> !equalizerCoeffRecalDone)
    else $error("coeff done held");
  chk_rdata_idle: assert property (!$past(busReq.rd) |-> busRdata == '0)
    else $error("read data off cycle");
endmodule

// ### sim/receiver_lock_manager_tb.sv
module receiver_lock_manager_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic                       mclk = 1'b0;
  logic                       rst = 1'b1;
  rlm_pkg::rlm_bus_req_t      busReq = '0;
  logic [rlm_pkg::DATA_W-1:0] busRdata;
  logic                       irq, dtm, valid, ready, actN, cal, eyeDone, coefDone;
  logic                       calReq = 1'b0, eyeReq = 1'b0, coefReq = 1'b0, los = 1'b0;
  logic                       sig = 1'b0, slow = 1'b0;
  logic [12:0]                ppm = 13'h0000;
  logic [7:0]                 starts;
  logic [7:0]                 flags;
  rlm_pkg::rlm_pma_stat_t     pmaStat;
  rlm_pkg::rlm_cal_cmd_t      calCmd;
  rlm_pkg::rlm_cal_kind_t     lastKind;
  int                         fail_count = 0;
  int                         samples_checked = 0;
  // 50 ns clock
  always #25 mclk = ~mclk;
  assign flags = {dtm, valid, !coefDone, coefDone, !eyeDone, eyeDone, !cal, cal};
  receiver_lock_manager receiver_lock_manager_inst (.mclk(mclk), .rst(rst), .busReq(busReq),
    .busRdata(busRdata), .irq(irq), .pmaStat(pmaStat), .calCmd(calCmd),
    .dataTrackingMode(dtm), .calRequest(calReq), .eyeRecalRequest(eyeReq),
    .equalizerCoeffRecalRequest(coefReq), .lossOfSignalIn(los), .rxDataValidFlag(valid),
    .rxReadyFlag(ready), .rxActiveN(actN), .calibrating(cal), .eyeRecalDone(eyeDone),
    .equalizerCoeffRecalDone(coefDone));
  rlm_pma_model rlm_pma_model_inst (.mclk(mclk), .rst(rst), .calCmd(calCmd), .sigIn(sig),
    .lockIn(1'b1), .ppmIn(ppm), .slowIn(slow), .pmaStat(pmaStat), .starts(starts),
    .lastKind(lastKind));
  task automatic finish_test;
    $display("compared %0d, mismatched %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Bounded wait on one flag
  task automatic wait_for(input int w, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge mclk);
      if (flags[w] === 1'b1) return;
    end
    check_word(32'h0, 32'h1);
    finish_test();
  endtask
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    busReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge mclk);
    busReq <= '0;
  endtask
  // Data stand one cycle
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    busReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge mclk);
    busReq <= '0;
    @(negedge mclk);
    check_word(busRdata, e);
  endtask
  task automatic do_reset;
    @(posedge mclk);
    rst <= 1'b1;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
  endtask
  // Hold request until done, then drop
  task automatic recal_one(input logic eye, input rlm_pkg::rlm_cal_kind_t k, input logic [7:0] n);
    @(posedge mclk);
    eyeReq <= eye;
    coefReq <= !eye;
    wait_for(eye ? 2 : 4, 40);
    check_word(32'(lastKind), 32'(k));
    check_word(32'(starts), 32'(n));
    @(posedge mclk);
    eyeReq <= 1'b0;
    coefReq <= 1'b0;
    wait_for(eye ? 3 : 5, 10);
  endtask
  task automatic test_regs;
    rd_chk(rlm_pkg::OFS_CTRL, 32'h0000_0001);
    rd_chk(rlm_pkg::OFS_MASK, 32'h0);
    rd_chk(8'h20, 32'h0);
    bus_wr(rlm_pkg::OFS_COEF, 32'h0000_A5C3);
    rd_chk(rlm_pkg::OFS_COEF, 32'h0000_A5C3);
    check_word(32'(calCmd.eqCoef), 32'h0000_A5C3);
    $display("test_regs finished");
  endtask
  // Low-rate first lock: activity, ready, full calibration, count and irq
  task automatic test_first_lock;
    check_word(32'(actN), 32'h1);
    @(posedge mclk) sig <= 1'b1;
    wait_for(6, 100);
    check_word(32'(actN), 32'h0);
    check_word(32'(ready), 32'h1);
    check_word(32'(lastKind), 32'(rlm_pkg::CAL_FULL));
    rd_chk(rlm_pkg::OFS_COUNT, 32'h1);
    check_word(32'(irq), 32'h0);
    bus_wr(rlm_pkg::OFS_MASK, 32'h1);
    repeat (2) @(negedge mclk);
    check_word(32'(irq), 32'h1);
    bus_wr(rlm_pkg::OFS_STATUS, 32'h1);
    repeat (2) @(negedge mclk);
    check_word(32'(irq), 32'h0);
    $display("test_first_lock finished");
  endtask
  task automatic test_lock_edge;
    @(posedge mclk) ppm <= 13'hFA1;
    repeat (3) @(negedge mclk);
    check_word(32'({ready, valid}), 32'h0);
    @(posedge mclk) ppm <= 13'hFA0;
    wait_for(6, 20);
    rd_chk(rlm_pkg::OFS_STATUS, 32'h8);
    $display("test_lock_edge finished");
  endtask
  task automatic test_on_demand;
    @(posedge mclk) sig <= 1'b0;
    do_reset();
    bus_wr(rlm_pkg::OFS_CTRL, 32'h2);
    @(posedge mclk) sig <= 1'b1;
    wait_for(6, 40);
    check_word(32'(starts), 32'h0);
    @(posedge mclk) calReq <= 1'b1;
    repeat (3) @(negedge mclk);
    check_word(32'(cal), 32'h0);
    wait_for(0, 10);
    wait_for(1, 40);
    repeat (20) @(negedge mclk);
    check_word(32'(starts), 32'h1);
    @(posedge mclk) calReq <= 1'b0;
    slow <= 1'b1;
    repeat (4) @(posedge mclk);
    calReq <= 1'b1;
    wait_for(0, 10);
    repeat (20) @(negedge mclk);
    check_word(32'(cal), 32'h1);
    wait_for(1, 80);
    check_word(32'(starts), 32'h2);
    @(posedge mclk) calReq <= 1'b0;
    slow <= 1'b0;
    recal_one(1'b1, rlm_pkg::CAL_EYE, 8'h03);
    recal_one(1'b0, rlm_pkg::CAL_COEFF, 8'h04);
    $display("test_on_demand finished");
  endtask
  task automatic test_fixed_eq;
    bus_wr(rlm_pkg::OFS_CTRL, 32'h3);
    recal_one(1'b0, rlm_pkg::CAL_COEFF, 8'h04);
    @(posedge mclk) calReq <= 1'b1;
    wait_for(0, 10);
    wait_for(1, 40);
    check_word(32'(lastKind), 32'(rlm_pkg::CAL_DC_OFFSET));
    check_word(32'(calCmd.eqAutoEn), 32'h0);
    @(posedge mclk) calReq <= 1'b0;
    $display("test_fixed_eq finished");
  endtask
  task automatic test_nocal;
    bus_wr(rlm_pkg::OFS_CTRL, 32'h0);
    @(posedge mclk) calReq <= 1'b1;
    repeat (10) @(negedge mclk);
    check_word(32'({dtm, cal}), 32'h0);
    @(posedge mclk) calReq <= 1'b0;
    recal_one(1'b1, rlm_pkg::CAL_DC_OFFSET, 8'h05);
    $display("test_nocal finished");
  endtask
  task automatic test_los;
    @(posedge mclk) los <= 1'b1;
    do_reset();
    repeat (20) @(negedge mclk);
    check_word(32'({dtm, starts}), 32'h0);
    @(posedge mclk) los <= 1'b0;
    wait_for(6, 200);
    @(posedge mclk) los <= 1'b1;
    repeat (10) @(negedge mclk);
    check_word(32'({dtm, valid}), 32'h3);
    $display("test_los finished");
  endtask
  initial begin
    do_reset();
    test_regs();
    test_first_lock();
    test_lock_edge();
    test_on_demand();
    test_fixed_eq();
    test_nocal();
    test_los();
    finish_test();
  end
endmodule
bind receiver_lock_manager rlm_properties rlm_properties_inst (.*);
